// *** src/tmc_timer_ctl.sv ***
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
// Contract
// - Two independent 16-bit up counters, software accessible.
// - Each counter takes its own mode 0-3.
// - External mode counts pin pulses during sleep.
// - Carry during sleep raises a wake request.
// - Run bits 4 and 6 enable counters.
// - Run/flag register bit layout as specified.
// - Mode register nibbles: gate, source, mode bits.
// - Internal clock: one tick per machine cycle.
// - Source bit selects count pin per counter.
// - Falling pin edge sets capture latch.
// - Latch copied to sync flop at phase five.
// - Pulse is sync AND phase three; clears latch.
// - Sleep bypasses detector; pin drives counter directly.
// - Gate on: count needs run and irq pin.
// - Gate off: run bit alone controls counting.
module tmc_timer_ctl (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire logic [tmc_pkg::TMC_ADDR_W-1:0] addr,
  input  wire logic [tmc_pkg::TMC_DATA_W-1:0] wdata,
  input  wire logic                     wr_stb,
  input  wire logic                     rd_stb,
  output logic      [tmc_pkg::TMC_DATA_W-1:0] rdata,
  input  wire logic                     count_pin_a,
  input  wire logic                     count_pin_b,
  input  wire logic                     ext_irq_pin_a,
  input  wire logic                     ext_irq_pin_b,
  input  wire logic                     soft_sleep_state,
  input  wire logic                     hard_sleep_state,
  output logic                          wake_req,
  output logic                          irq
);
  import tmc_pkg::*;

  logic [7:0]           run_flags_reg;
  logic [7:0]           mode_sel_reg;
  logic [7:0]           lo_reg [2];
  logic [7:0]           hi_reg [2];
  logic [3:0]           phase_reg;
  logic [1:0]           irq_pin_reg;
  logic [7:0]           rdata_reg;
  logic                 wake_req_reg;
  logic [TMC_IRQ_W-1:0] irq_stat_reg;
  logic [TMC_IRQ_W-1:0] irq_mask_reg;
  logic [TMC_IRQ_W-1:0] irq_set;

  logic      sleep;
  logic      phase_three;
  logic      phase_five;
  logic      int_pulse;
  logic [1:0] count_pins;
  logic [1:0] irq_pins;
  logic [1:0] run_bits;
  logic [1:0] gate_bits;
  logic [1:0] csel_bits;
  logic [1:0] ext_pulse;
  logic [1:0] cnt_en;
  logic [1:0] tick_lo;
  logic [1:0] ovf_lo;
  logic [1:0] wr_lo;
  logic [1:0] wr_hi;
  logic [1:0] irq_fall;
  tmc_mode_e  mode_v [2];
  logic      hi_split_tick;
  logic      hi_split_ovf;
  logic      ovf_set_a;
  logic      ovf_set_b;
  logic      wr_run_flags;

  assign sleep      = soft_sleep_state | hard_sleep_state;
  assign count_pins = {count_pin_b, count_pin_a};
  assign irq_pins   = {ext_irq_pin_b, ext_irq_pin_a};
  assign run_bits   = {run_flags_reg[TMC_BIT_RUN_B], run_flags_reg[TMC_BIT_RUN_A]};
  assign wr_run_flags = wr_stb && (addr == TMC_OFF_RUN_FLAGS);

  // Machine-cycle phase counter; frozen in sleep since the oscillator stops there
  always_ff @(posedge mclk) begin
    if (srst) begin
      phase_reg <= '0;
    end else if (!sleep) begin
      phase_reg <= (phase_reg == TMC_PH_LAST) ? 4'h0 : phase_reg + 4'h1;
    end
  end

  assign phase_three = !sleep && (phase_reg == TMC_PH_THREE);
  assign phase_five  = !sleep && (phase_reg == TMC_PH_FIVE);
  assign int_pulse   = phase_three;

  // One falling-edge detector per count pin
  for (genvar g = 0; g < 2; g++) begin : g_det
    tmc_edge_det u_det (
      .mclk        (mclk),
      .srst        (srst),
      .pin         (count_pins[g]),
      .phase_three (phase_three),
      .phase_five  (phase_five),
      .bypass      (sleep),
      .cnt_pulse   (ext_pulse[g])
    );
  end

  // Per-counter decode of mode nibble, run condition and count tick
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      mode_v[i]    = tmc_mode_e'(mode_sel_reg[TMC_NIB_W*i + TMC_FLD_MODE +: 2]);
      gate_bits[i] = mode_sel_reg[TMC_NIB_W*i + TMC_FLD_GATE];
      csel_bits[i] = mode_sel_reg[TMC_NIB_W*i + TMC_FLD_CSEL];
      cnt_en[i]    = run_bits[i] & (~gate_bits[i] | irq_pins[i]);
      tick_lo[i]   = cnt_en[i] & (csel_bits[i] ? ext_pulse[i] : int_pulse);
    end
    // Counter b does not run while itself in split mode
    if (mode_v[1] == TMC_MODE_SPLIT8) begin
      cnt_en[1]  = 1'b0;
      tick_lo[1] = 1'b0;
    end
  end

  // Carry out of each counter, by mode
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      case (mode_v[i])
        TMC_MODE_13BIT:  ovf_lo[i] = tick_lo[i] && (lo_reg[i][4:0] == TMC_M13_FULL) && (hi_reg[i] == TMC_BYTE_FULL);
        TMC_MODE_16BIT:  ovf_lo[i] = tick_lo[i] && (lo_reg[i] == TMC_BYTE_FULL) && (hi_reg[i] == TMC_BYTE_FULL);
        default:         ovf_lo[i] = tick_lo[i] && (lo_reg[i] == TMC_BYTE_FULL);
      endcase
    end
  end

  // Split mode: high byte of counter a runs on internal clock under run_ctl_b
  assign hi_split_tick = (mode_v[0] == TMC_MODE_SPLIT8) && run_bits[1] && int_pulse;
  assign hi_split_ovf  = hi_split_tick && (hi_reg[0] == TMC_BYTE_FULL);
  assign ovf_set_a     = ovf_lo[0];
  assign ovf_set_b     = (mode_v[0] == TMC_MODE_SPLIT8) ? hi_split_ovf : ovf_lo[1];

  // Counter byte write strobes
  assign wr_lo = {wr_stb && (addr == TMC_OFF_CNT_LO_B), wr_stb && (addr == TMC_OFF_CNT_LO_A)};
  assign wr_hi = {wr_stb && (addr == TMC_OFF_CNT_HI_B), wr_stb && (addr == TMC_OFF_CNT_HI_A)};

  // Counter bytes; a software write beats a count in the same cycle
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (srst) begin
        lo_reg[i] <= TMC_RST_CNT;
        hi_reg[i] <= TMC_RST_CNT;
      end else begin
        if (wr_lo[i]) begin
          lo_reg[i] <= wdata;
        end else if (tick_lo[i]) begin
          if (mode_v[i] == TMC_MODE_RELOAD8 && lo_reg[i] == TMC_BYTE_FULL) begin
            lo_reg[i] <= hi_reg[i];
          end else begin
            lo_reg[i] <= lo_reg[i] + 8'h01;
          end
        end
        if (wr_hi[i]) begin
          hi_reg[i] <= wdata;
        end else if (i == 0 && hi_split_tick) begin
          hi_reg[i] <= hi_reg[i] + 8'h01;
        end else if (tick_lo[i] && ((mode_v[i] == TMC_MODE_13BIT && lo_reg[i][4:0] == TMC_M13_FULL) ||
                                    (mode_v[i] == TMC_MODE_16BIT && lo_reg[i] == TMC_BYTE_FULL))) begin
          hi_reg[i] <= hi_reg[i] + 8'h01;
        end
      end
    end
  end

  // Sampled interrupt pins for edge-type flags
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_pin_reg <= 2'h3;
    end else begin
      irq_pin_reg <= irq_pins;
    end
  end

  assign irq_fall = irq_pin_reg & ~irq_pins;

  // Run and flag register; hardware sets win over a software clear
  always_ff @(posedge mclk) begin
    if (srst) begin
      run_flags_reg <= TMC_RST_RUN_FLAGS;
    end else begin
      if (wr_run_flags) begin
        run_flags_reg <= wdata;
      end
      if (ovf_set_a) begin
        run_flags_reg[TMC_BIT_OVF_A] <= 1'b1;
      end
      if (ovf_set_b) begin
        run_flags_reg[TMC_BIT_OVF_B] <= 1'b1;
      end
      // Edge type latches a falling edge; level type follows the low pin
      if (run_flags_reg[TMC_BIT_EIT_A]) begin
        if (irq_fall[0]) run_flags_reg[TMC_BIT_EIF_A] <= 1'b1;
      end else begin
        run_flags_reg[TMC_BIT_EIF_A] <= ~irq_pins[0];
      end
      if (run_flags_reg[TMC_BIT_EIT_B]) begin
        if (irq_fall[1]) run_flags_reg[TMC_BIT_EIF_B] <= 1'b1;
      end else begin
        run_flags_reg[TMC_BIT_EIF_B] <= ~irq_pins[1];
      end
    end
  end

  // Mode select register
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_sel_reg <= TMC_RST_MODE_SEL;
    end else if (wr_stb && addr == TMC_OFF_MODE_SEL) begin
      mode_sel_reg <= wdata;
    end
  end

  // Wake request: one pulse per carry while asleep
  always_ff @(posedge mclk) begin
    if (srst) begin
      wake_req_reg <= 1'b0;
    end else begin
      wake_req_reg <= sleep && (ovf_set_a || ovf_set_b);
    end
  end

  assign wake_req = wake_req_reg;

  // Sticky interrupt status, write one to clear; set wins
  assign irq_set = {wake_req_reg, ovf_set_b, ovf_set_a};

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_stat_reg <= TMC_RST_IRQ;
      irq_mask_reg <= TMC_RST_IRQ;
    end else begin
      if (wr_stb && addr == TMC_OFF_IRQ_STAT) begin
        irq_stat_reg <= (irq_stat_reg & ~wdata[TMC_IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      if (wr_stb && addr == TMC_OFF_IRQ_MASK) begin
        irq_mask_reg <= wdata[TMC_IRQ_W-1:0];
      end
    end
  end

  // Level interrupt while any unmasked status bit stands
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read data the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdata_reg <= 8'h00;
    end else if (rd_stb) begin
      case (addr)
        TMC_OFF_RUN_FLAGS: rdata_reg <= run_flags_reg;
        TMC_OFF_MODE_SEL:  rdata_reg <= mode_sel_reg;
        TMC_OFF_CNT_LO_A:  rdata_reg <= lo_reg[0];
        TMC_OFF_CNT_LO_B:  rdata_reg <= lo_reg[1];
        TMC_OFF_CNT_HI_A:  rdata_reg <= hi_reg[0];
        TMC_OFF_CNT_HI_B:  rdata_reg <= hi_reg[1];
        TMC_OFF_IRQ_STAT:  rdata_reg <= {5'h00, irq_stat_reg};
        TMC_OFF_IRQ_MASK:  rdata_reg <= {5'h00, irq_mask_reg};
        default:           rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign rdata = rdata_reg;

  // Checks on the counting control
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_run_hold:     assert property (!cnt_en[0] && !wr_lo[0] && !wr_hi[0] && mode_v[0] != TMC_MODE_SPLIT8
                                   |=> lo_reg[0] == $past(lo_reg[0]) && hi_reg[0] == $past(hi_reg[0]))
    else $error("stopped counter a changed value");
  a_gate_block:   assert property (gate_bits[0] && run_bits[0] && !ext_irq_pin_a && !wr_lo[0]
                                   |=> lo_reg[0] == $past(lo_reg[0]))
    else $error("gated counter a counted with irq pin low");
  a_int_tick:     assert property (run_bits[0] && !gate_bits[0] && !csel_bits[0] && mode_v[0] == TMC_MODE_16BIT
                                   && phase_three && !wr_lo[0] |=> lo_reg[0] == $past(lo_reg[0]) + 8'h01)
    else $error("internal tick did not add one");
  a_int_period:   assert property (phase_three |=> !phase_three[*8])
    else $error("internal tick more than once per machine cycle");
  a_sleep_count:  assert property (sleep && run_bits[0] && !gate_bits[0] && csel_bits[0] && mode_v[0] == TMC_MODE_16BIT
                                   && ext_pulse[0] && !wr_lo[0] |=> lo_reg[0] == $past(lo_reg[0]) + 8'h01)
    else $error("pin pulse not counted in sleep");
  a_ovf_flag:     assert property (ovf_set_a |=> run_flags_reg[TMC_BIT_OVF_A])
    else $error("carry did not set overflow_flag_a");
  a_wake_req:     assert property (sleep && (ovf_set_a || ovf_set_b) |=> wake_req ##1 irq_stat_reg[TMC_IRQ_WAKE])
    else $error("carry in sleep gave no wake request");
  a_split_halt:   assert property (mode_v[1] == TMC_MODE_SPLIT8 && !wr_lo[1] |=> $stable(lo_reg[1]))
    else $error("counter b ran in split mode");
  a_read_mode:    assert property (rd_stb && addr == TMC_OFF_MODE_SEL && !wr_stb
                                   |=> rdata == $past(mode_sel_reg))
    else $error("mode register read back wrong");

  c_ext_count:    cover property (!sleep && tick_lo[0] && csel_bits[0]);
  c_ovf_a:        cover property (ovf_set_a ##1 irq);
  c_wake:         cover property (sleep ##1 wake_req);
  c_split_carry:  cover property (hi_split_ovf);

endmodule : tmc_timer_ctl

// *** include/tmc_pkg.sv ***
package tmc_pkg;

  // Register bus geometry
  localparam int unsigned TMC_ADDR_W = 8;
  localparam int unsigned TMC_DATA_W = 8;

  // Register offsets
  localparam logic [7:0] TMC_OFF_RUN_FLAGS = 8'h88;
  localparam logic [7:0] TMC_OFF_MODE_SEL  = 8'h89;
  localparam logic [7:0] TMC_OFF_CNT_LO_A  = 8'h8a;
  localparam logic [7:0] TMC_OFF_CNT_LO_B  = 8'h8b;
  localparam logic [7:0] TMC_OFF_CNT_HI_A  = 8'h8c;
  localparam logic [7:0] TMC_OFF_CNT_HI_B  = 8'h8d;
  localparam logic [7:0] TMC_OFF_IRQ_STAT  = 8'h90;
  localparam logic [7:0] TMC_OFF_IRQ_MASK  = 8'h91;

  // Bits of timer_run_and_flags
  localparam int unsigned TMC_BIT_OVF_B = 7;
  localparam int unsigned TMC_BIT_RUN_B = 6;
  localparam int unsigned TMC_BIT_OVF_A = 5;
  localparam int unsigned TMC_BIT_RUN_A = 4;
  localparam int unsigned TMC_BIT_EIF_B = 3;
  localparam int unsigned TMC_BIT_EIT_B = 2;
  localparam int unsigned TMC_BIT_EIF_A = 1;
  localparam int unsigned TMC_BIT_EIT_A = 0;

  // Fields of one timer_mode_select nibble; counter b sits one nibble up
  localparam int unsigned TMC_NIB_W     = 4;
  localparam int unsigned TMC_FLD_GATE  = 3;
  localparam int unsigned TMC_FLD_CSEL  = 2;
  localparam int unsigned TMC_FLD_MODE  = 0;

  // Interrupt status and mask bits
  localparam int unsigned TMC_IRQ_W     = 3;
  localparam int unsigned TMC_IRQ_OVF_A = 0;
  localparam int unsigned TMC_IRQ_OVF_B = 1;
  localparam int unsigned TMC_IRQ_WAKE  = 2;

  // Reset values
  localparam logic [7:0]           TMC_RST_RUN_FLAGS = 8'h00;
  localparam logic [7:0]           TMC_RST_MODE_SEL  = 8'h00;
  localparam logic [7:0]           TMC_RST_CNT       = 8'h00;
  localparam logic [TMC_IRQ_W-1:0] TMC_RST_IRQ       = 3'h0;

  // Machine cycle: twelve oscillator periods, six phases of two periods
  localparam int unsigned TMC_OSC_DIV  = 12;
  localparam int unsigned TMC_PHASE_W  = 4;
  localparam logic [3:0]  TMC_PH_THREE = 4'h4;
  localparam logic [3:0]  TMC_PH_FIVE  = 4'h8;
  localparam logic [3:0]  TMC_PH_LAST  = 4'(TMC_OSC_DIV - 1);

  // Counter values that produce carries
  localparam logic [7:0] TMC_BYTE_FULL = 8'hff;
  localparam logic [4:0] TMC_M13_FULL  = 5'h1f;

  // Counter operating modes, in the order of the two mode bits
  typedef enum logic [1:0] {
    TMC_MODE_13BIT,
    TMC_MODE_16BIT,
    TMC_MODE_RELOAD8,
    TMC_MODE_SPLIT8
  } tmc_mode_e;

endpackage : tmc_pkg

// *** src/tmc_edge_det.sv ***
`timescale 1ns/100ps
module tmc_edge_det (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic pin,
  input  wire logic phase_three,
  input  wire logic phase_five,
  input  wire logic bypass,
  output logic      cnt_pulse
);
  import tmc_pkg::*;

  logic pin_reg;
  logic edge_capture_latch_reg;
  logic phase_sync_flop_reg;
  logic fall;

  // Falling transition of the count pin
  assign fall = pin_reg & ~pin;

  always_ff @(posedge mclk) begin
    if (srst) begin
      pin_reg <= 1'b1;
    end else begin
      pin_reg <= pin;
    end
  end

  // First latch: a new edge wins over the clear by its own pulse
  always_ff @(posedge mclk) begin
    if (srst) begin
      edge_capture_latch_reg <= 1'b0;
    end else if (fall && !bypass) begin
      edge_capture_latch_reg <= 1'b1;
    end else if (cnt_pulse || bypass) begin
      edge_capture_latch_reg <= 1'b0;
    end
  end

  // Second flop loads only at phase five
  always_ff @(posedge mclk) begin
    if (srst || bypass) begin
      phase_sync_flop_reg <= 1'b0;
    end else if (phase_five) begin
      phase_sync_flop_reg <= edge_capture_latch_reg;
    end
  end

  // Sleep bypass: edge goes straight to the counter, no phases run
  assign cnt_pulse = bypass ? fall : (phase_sync_flop_reg & phase_three);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_latch_set:    assert property (fall && !bypass |=> edge_capture_latch_reg)
    else $error("falling pin edge not captured");
  a_latch_clear:  assert property (cnt_pulse && !bypass && !fall |=> !edge_capture_latch_reg)
    else $error("count pulse did not clear capture latch");
  a_sync_phase:   assert property (!phase_five && !bypass |=> $stable(phase_sync_flop_reg))
    else $error("sync flop changed outside phase five");
  a_pulse_space:  assert property (cnt_pulse && !bypass |=> (!cnt_pulse || bypass)[*8])
    else $error("two detector pulses in one machine cycle");
  a_bypass_pass:  assert property (bypass && fall |-> cnt_pulse)
    else $error("bypassed edge did not pulse");

endmodule : tmc_edge_det

// *** tb/tmc_pin_src.sv ***
`timescale 1ns/100ps
// Pulse source on one count pin; the pin idles high between bursts
module tmc_pin_src (
  input  wire logic mclk,
  output logic      pin
);
  initial pin = 1'b1;

  // Each level is held w cycles; w below 10 would let the detector miss edges
  task automatic burst(input int n, input int w);
    repeat (n) begin
      @(posedge mclk);
      pin <= 1'b0;
      repeat (w) @(posedge mclk);
      pin <= 1'b1;
      repeat (w - 1) @(posedge mclk);
    end
  endtask : burst
endmodule : tmc_pin_src

// *** tb/timer01_count_control_tb.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module timer01_count_control_tb;
  import tmc_pkg::*;
  logic       mclk  = 1'b0;
  logic       srst  = 1'b1;
  logic [7:0] addr  = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr_stb = 1'b0;
  logic       rd_stb = 1'b0;
  logic [7:0] rdata;
  logic       pin_a;
  logic       pin_b;
  logic       irq_pin_a = 1'b1;
  logic       irq_pin_b = 1'b1;
  logic       soft_slp = 1'b0;
  logic       hard_slp = 1'b0;
  logic       wake_req;
  logic       irq;
  logic [7:0] rv;
  int         fails = 0;
  int         checked = 0;
  int         wakes = 0;
  int         k;
  logic [7:0] v;
  logic [7:0] regs [9] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'h90, 8'h91, 8'h80};

  tmc_timer_ctl DUT (
    .mclk             (mclk),
    .srst             (srst),
    .addr             (addr),
    .wdata            (wdata),
    .wr_stb           (wr_stb),
    .rd_stb           (rd_stb),
    .rdata            (rdata),
    .count_pin_a      (pin_a),
    .count_pin_b      (pin_b),
    .ext_irq_pin_a    (irq_pin_a),
    .ext_irq_pin_b    (irq_pin_b),
    .soft_sleep_state (soft_slp),
    .hard_sleep_state (hard_slp),
    .wake_req         (wake_req),
    .irq              (irq)
  );
  tmc_pin_src src_a (.mclk(mclk), .pin(pin_a));
  tmc_pin_src src_b (.mclk(mclk), .pin(pin_b));

  always #10 mclk = ~mclk;

  // Count wake pulses; each stands one cycle only
  always @(posedge mclk) begin
    if (wake_req === 1'b1) begin
      wakes++;
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask : wr

  // Register read; data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    rv = rdata;
  endtask : rd

  // Run for exactly 12*k edges: any such span holds exactly k ticks
  task automatic count_win(input logic [7:0] modev, input logic [7:0] runv, input logic gp,
                           input bit a_on, input bit b_on);
    k = 2 + $urandom % 8;
    irq_pin_a <= gp;
    irq_pin_b <= gp;
    wr(8'h88, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h8a + 8'(i), (i < 2) ? 8'hff : 8'h00);
    end
    wr(8'h89, modev);
    wr(8'h88, runv);
    repeat (12 * k - 2) @(posedge mclk);
    wr(8'h88, 8'h00);
    // Stopped counters must hold while idle
    repeat (24) @(posedge mclk);
    rd(8'h8a);
    `CHK(rv, a_on ? 8'(k - 1) : 8'hff)
    rd(8'h8c);
    `CHK(rv, a_on ? 8'h01 : 8'h00)
    rd(8'h8b);
    `CHK(rv, b_on ? 8'(k - 1) : 8'hff)
    rd(8'h8d);
    `CHK(rv, b_on ? 8'h01 : 8'h00)
    $display("test count window mode %h run %h finished", modev, runv);
  endtask : count_win

  initial begin
    repeat (100000) @(posedge mclk);
    $display("unexpected at %0t: run limit reached", $time);
    fails++;
    final_report;
  end

  initial begin
    void'($urandom(36806));
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    // Reset values, plus an unmapped address that reads zero
    foreach (regs[i]) begin
      rd(regs[i]);
      `CHK(rv, 8'h00)
    end
    // Every mode code on each counter, set independently
    for (int m = 0; m < 4; m++) begin
      v = {2'($urandom), 2'(3 - m), 2'($urandom), 2'(m)};
      wr(8'h89, v);
      rd(8'h89);
      `CHK(rv, v)
    end
    $display("test reset and modes finished");
    count_win(8'h01, 8'h10, 1'b0, 1'b1, 1'b0);
    count_win(8'h09, 8'h10, 1'b0, 1'b0, 1'b0);
    count_win(8'h09, 8'h10, 1'b1, 1'b1, 1'b0);
    count_win(8'h11, 8'h40, 1'b1, 1'b0, 1'b1);
    // Both counters gated by their own irq pins
    count_win(8'h99, 8'h50, 1'b0, 1'b0, 1'b0);
    count_win(8'h99, 8'h50, 1'b1, 1'b1, 1'b1);
    // Pin counting while awake, through the edge detector
    for (int s = 0; s < 2; s++) begin
      k = 2 + $urandom % 4;
      wr(8'h88, 8'h00);
      wr(8'h8a + 8'(s), 8'h00);
      wr(8'h89, s ? 8'h50 : 8'h05);
      wr(8'h88, s ? 8'h40 : 8'h10);
      if (s) begin
        src_b.burst(k, 24);
      end else begin
        src_a.burst(k, 24);
      end
      repeat (30) @(posedge mclk);
      wr(8'h88, 8'h00);
      rd(8'h8a + 8'(s));
      `CHK(rv, 8'(k))
    end
    $display("test pin count finished");
    // Pin counting in each sleep state, carry wakes and raises the interrupt
    for (int s = 0; s < 2; s++) begin
      wr(8'h88, 8'h00);
      wr(8'h8a, 8'hfe);
      wr(8'h8c, 8'hff);
      wr(8'h89, 8'h05);
      wr(8'h88, 8'h10);
      wakes = 0;
      soft_slp <= (s == 0);
      hard_slp <= (s == 1);
      src_a.burst(2, 12);
      repeat (4) @(posedge mclk);
      `CHK(wakes, 1)
      soft_slp <= 1'b0;
      hard_slp <= 1'b0;
      rd(8'h8a);
      `CHK(rv, 8'h00)
      rd(8'h8c);
      `CHK(rv, 8'h00)
      rd(8'h88);
      `CHK(rv, 8'h30)
      rd(8'h90);
      `CHK(rv, 8'h05)
      `CHK(irq, 1'b0)
      wr(8'h91, 8'h04);
      #1;
      `CHK(irq, 1'b1)
      wr(8'h90, 8'h05);
      #1;
      `CHK(irq, 1'b0)
      wr(8'h91, 8'h00);
    end
    $display("test sleep wake finished");
    final_report;
  end
endmodule : timer01_count_control_tb
